/* File: common/tct_cfg.svh */
// Constants of the tick clock timer: register offsets, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the top design file and the bench.
`ifndef TCT_CFG_SVH
`define TCT_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets in the processor I/O memory.
// ----------------------------------------------------------------------
`define TCT_ADDR_CTRL 16'hff74
`define TCT_ADDR_LOW 16'hff75
`define TCT_ADDR_HIGH 16'hff76
`define TCT_ADDR_EN 16'hffe5
`define TCT_ADDR_FLAG 16'hfff5

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define TCT_CTRL_RUN_BIT 0
`define TCT_CTRL_CLR_BIT 1
`define TCT_RST_NIB 4'h0
`define TCT_RST_COUNT 8'h00

// ----------------------------------------------------------------------
// Timing: clock period, least hold time, oscillator prescale ratio.
// ----------------------------------------------------------------------
`define TCT_CLK_PERIOD_NS 100
`define TCT_HOLD_MIN_NS 480000
`define TCT_HOLD_CYCLES \
  ((`TCT_HOLD_MIN_NS + `TCT_CLK_PERIOD_NS - 1) / `TCT_CLK_PERIOD_NS)
`define TCT_PRESC_DIV 128

`endif

/* File: common/tct_pkg.sv */
// Types shared by the tick clock timer design files.
// Assumes tct_cfg.svh is on the include path.
`default_nettype none

package tct_pkg;
  typedef logic [15:0] tct_addr_t;
  typedef logic [3:0] tct_nib_t;
  // Carry path into the high word: free or held after a low read.
  typedef enum logic {TCT_FREE, TCT_HELD} tct_hold_t;
endpackage : tct_pkg

`default_nettype wire

/* File: rtl/tct_tap_flag.sv */
// One sticky tap interrupt flag of the tick clock timer.
// Assumes fall_i marks the counting step on which the tap falls.
`default_nettype none

module tct_tap_flag (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic fall_i,
  input wire logic clear_i,
  output logic flag_o
);
  import tct_pkg::*;

  // ---------------------------------------------------------------------
  // Flag register.
  // ---------------------------------------------------------------------
  // A falling tap sets the flag whatever the mask; it beats a clear.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      flag_o <= 1'b0;
    end else if (ce_i) begin
      if (fall_i) begin
        flag_o <= 1'b1; // R06 R07
      end else if (clear_i) begin
        flag_o <= 1'b0; // R14
      end
    end
  end
endmodule : tct_tap_flag

`default_nettype wire

/* File: rtl/tct_top.sv */
// Tick clock timer: 8-bit count of a prescaled low-speed oscillator, read
// as two 4-bit words, with high-word hold and four tap interrupts.
// Assumes all inputs synchronous to clock_i and one-cycle access strobes.
//
// Notes on behaviour
// R01: Count is an 8-bit binary up-counter stepped by the prescaled oscillator.
// R02: Low word, bits toggling 128 to 16 Hz, reads at the low address.
// R03: High word, bits toggling 8 to 1 Hz, reads at the high address.
// R04: Reading low suspends carries to high until high is read or timeout.
// R05: Software reads the low word first; high first gives no hold.
// R06: Falling edges of 32, 8, 2 and 1 Hz taps set own flags.
// R07: Flags set on their edge even while the matching enable is zero.
// R08: One read/write enable bit per tap, 1 enables, all reset to 0.
// R09: Writing 1 to clear bit zeroes the count; it always reads 0.
// R10: Unused control bits read as zero and ignore writes.
// R11: Run bit starts or stops counting, reads back, resets to 0.
// R12: Stopped count is kept and counting resumes from it.
// R13: Clear while running restarts from zero; while stopped zero is held.
// R14: Writing 1 to a flag clears it, 0 does nothing, reset to 0.
// R15: Interrupt request is high while any enabled flag is set.
// R16: Reset clears count, run bit and enable bits.
`default_nettype none
`include "tct_cfg.svh"

module tct_top #(
  parameter int HOLD_CYCLES = `TCT_HOLD_CYCLES,
  parameter int PRESC_DIV = `TCT_PRESC_DIV
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic low_speed_oscillator_i,
  input wire tct_pkg::tct_addr_t mem_addr_i,
  input wire logic mem_wr_i,
  input wire logic mem_rd_i,
  input wire tct_pkg::tct_nib_t mem_wdata_i,
  output tct_pkg::tct_nib_t mem_rdata_o,
  output logic irq_o
);
  import tct_pkg::*;

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam int PW = $clog2(PRESC_DIV);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);
  localparam logic [PW-1:0] PRESC_LAST = PW'(PRESC_DIV - 1);

  // ---------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------
  logic osc_prev;
  logic [PW-1:0] presc;
  tct_nib_t count_low;
  tct_nib_t count_high;
  logic count_run_control;
  tct_hold_t hold_state;
  logic [HW-1:0] hold_cnt;
  logic carry_pend;
  tct_nib_t irq_enable;
  tct_nib_t irq_flag;

  // ---------------------------------------------------------------------
  // Access decode.
  // ---------------------------------------------------------------------
  // Address matches qualified by the strobes and the clock enable.
  wire logic sel_ctrl = mem_addr_i == `TCT_ADDR_CTRL;
  wire logic sel_low = mem_addr_i == `TCT_ADDR_LOW;
  wire logic sel_high = mem_addr_i == `TCT_ADDR_HIGH;
  wire logic sel_en = mem_addr_i == `TCT_ADDR_EN;
  wire logic sel_flag = mem_addr_i == `TCT_ADDR_FLAG;
  wire logic wr_ctrl = ce_i && mem_wr_i && sel_ctrl;
  wire logic wr_en = ce_i && mem_wr_i && sel_en;
  wire logic wr_flag = ce_i && mem_wr_i && sel_flag;
  wire logic rd_low = ce_i && mem_rd_i && sel_low;
  wire logic rd_high = ce_i && mem_rd_i && sel_high;
  wire logic count_clear_strobe =
    wr_ctrl && mem_wdata_i[`TCT_CTRL_CLR_BIT]; // R09

  // ---------------------------------------------------------------------
  // Counting step and carry.
  // ---------------------------------------------------------------------
  // The count steps once per PRESC_DIV oscillator rising edges, so the
  // low bit toggles at the 128 Hz rate from a 32 kHz oscillator.
  wire logic osc_rise = low_speed_oscillator_i && !osc_prev;
  wire logic tick = ce_i && count_run_control && osc_rise &&
    presc == PRESC_LAST && !count_clear_strobe; // R01 R11
  wire logic low_wrap = tick && count_low == 4'hf;
  wire logic held = hold_state == TCT_HELD;
  wire logic hold_end = ce_i && held &&
    (rd_high || hold_cnt == HOLD_LAST); // R04
  // A carry taken while held is applied once the hold ends. A clear wins
  // over a pending carry, so it neither moves the count nor sets a flag.
  wire logic inc_high = !count_clear_strobe && ((low_wrap && !held) ||
    (hold_end && (carry_pend || low_wrap))); // R04
  wire tct_nib_t low_plus = count_low + 4'h1;
  wire tct_nib_t high_plus = count_high + 4'h1;

  // Tap falls: 32 Hz is bit 2, 8 Hz bit 4, 2 Hz bit 6, 1 Hz bit 7.
  wire tct_nib_t tap_fall = {
    inc_high && (&count_high[3:0]),
    inc_high && (&count_high[2:0]),
    inc_high && count_high[0],
    tick && (&count_low[2:0])
  }; // R06

  wire logic next_irq = |(irq_flag & irq_enable); // R15

  // Read mux; unused bits and unmapped addresses read as zero.
  wire tct_nib_t ctrl_rd = {3'b000, count_run_control}; // R09 R10
  wire tct_nib_t next_rdata =
    sel_ctrl ? ctrl_rd :
    sel_low ? count_low : // R02
    sel_high ? count_high : // R03
    sel_en ? irq_enable :
    sel_flag ? irq_flag : `TCT_RST_NIB;

  // ---------------------------------------------------------------------
  // Prescaler.
  // ---------------------------------------------------------------------
  // The prescaler restarts on a clear so counting restarts at once.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      osc_prev <= 1'b0;
      presc <= '0;
    end else if (ce_i) begin
      osc_prev <= low_speed_oscillator_i;
      if (count_clear_strobe) begin
        presc <= '0; // R13
      end else if (count_run_control && osc_rise) begin
        presc <= (presc == PRESC_LAST) ? '0 : PW'(presc + 1'b1);
      end
    end
  end

  // ---------------------------------------------------------------------
  // Counter and run control.
  // ---------------------------------------------------------------------
  // A stopped count keeps its value; a clear wins over a step.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      count_low <= `TCT_RST_NIB; // R16
      count_high <= `TCT_RST_NIB; // R16
      count_run_control <= 1'b0; // R16
    end else if (ce_i) begin
      if (wr_ctrl) begin
        count_run_control <= mem_wdata_i[`TCT_CTRL_RUN_BIT]; // R11
      end
      if (count_clear_strobe) begin
        count_low <= `TCT_RST_NIB; // R09 R13
        count_high <= `TCT_RST_NIB; // R09 R13
      end else begin
        if (tick) begin
          count_low <= low_plus; // R01 R12
        end
        if (inc_high) begin
          count_high <= high_plus; // R01
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // High-word hold.
  // ---------------------------------------------------------------------
  // A low read arms the hold; a high read or the timeout releases it.
  // Reading high first arms nothing, so the pair may be torn.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      hold_state <= TCT_FREE;
      hold_cnt <= '0;
      carry_pend <= 1'b0;
    end else if (ce_i) begin
      case (hold_state)
        TCT_FREE: begin
          hold_cnt <= '0;
          carry_pend <= 1'b0;
          if (rd_low && !count_clear_strobe) begin
            hold_state <= TCT_HELD; // R04 R05
          end
        end
        TCT_HELD: begin
          hold_cnt <= HW'(hold_cnt + 1'b1);
          if (count_clear_strobe || hold_end) begin
            hold_state <= TCT_FREE; // R04
            carry_pend <= 1'b0;
          end else if (low_wrap) begin
            carry_pend <= 1'b1; // R04
          end
        end
        default: begin
          hold_state <= TCT_FREE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt enables, read data and request output.
  // ---------------------------------------------------------------------
  // Read data is registered and stays until the next read.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      irq_enable <= `TCT_RST_NIB; // R08 R16
      mem_rdata_o <= `TCT_RST_NIB;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      if (wr_en) begin
        irq_enable <= mem_wdata_i; // R08
      end
      if (mem_rd_i) begin
        mem_rdata_o <= next_rdata;
      end
      irq_o <= next_irq; // R15
    end
  end

  // ---------------------------------------------------------------------
  // Tap flags.
  // ---------------------------------------------------------------------
  // One sticky flag per tap; a written 1 clears it.
  for (genvar i = 0; i < 4; i++) begin : g_tap
    tct_tap_flag u_flag (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .fall_i(tap_fall[i]),
      .clear_i(wr_flag && mem_wdata_i[i]), // R14
      .flag_o(irq_flag[i])
    );
  end

  // ---------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence s_clear_write;
    ce_i && mem_wr_i && sel_ctrl && mem_wdata_i[`TCT_CTRL_CLR_BIT];
  endsequence

  sequence s_low_read;
    ce_i && mem_rd_i && sel_low && hold_state == TCT_FREE &&
      !count_clear_strobe;
  endsequence

  sequence s_held_cycle;
    ce_i && held && !rd_high && !count_clear_strobe &&
      hold_cnt != HOLD_LAST;
  endsequence

  a_clear_zeroes: assert property (s_clear_write |=> // R09
    count_low == 4'h0 && count_high == 4'h0)
    else $error("count not zero after clear write");

  a_ctrl_read_val: assert property ( // R10
    ce_i && mem_rd_i && sel_ctrl |=>
      mem_rdata_o == {3'b000, $past(count_run_control)})
    else $error("control read gave wrong bits");

  a_stop_keeps: assert property ( // R12
    !count_run_control && !count_clear_strobe |=>
      $stable(count_low) && $stable(count_high))
    else $error("stopped count changed");

  a_run_write: assert property ( // R11
    wr_ctrl |=> count_run_control == $past(mem_wdata_i[0]))
    else $error("run bit did not follow write");

  a_hold_high: assert property (s_low_read ##1 s_held_cycle // R04
    |=> $stable(count_high))
    else $error("high word moved while held");

  a_hold_bound: assert property ( // R04
    held |-> hold_cnt < HW'(HOLD_CYCLES))
    else $error("hold outlasted its limit");

  a_flag_set: assert property (ce_i && tap_fall != 4'h0 // R06 R07
    |=> (irq_flag & $past(tap_fall)) == $past(tap_fall))
    else $error("tap fall did not set its flag");

  a_flag_clear: assert property (wr_flag && tap_fall == 4'h0 // R14
    |=> (irq_flag & $past(mem_wdata_i)) == 4'h0)
    else $error("flag not cleared by written one");

  a_mask_write: assert property ( // R08
    wr_en |=> irq_enable == $past(mem_wdata_i))
    else $error("enable register did not take write");

  a_irq_follow: assert property (ce_i && next_irq // R15
    |=> irq_o)
    else $error("enabled flag gave no request");

  a_clear_noflag: assert property (s_clear_write |-> // R09
    tap_fall == 4'h0)
    else $error("clear write raised a tap fall");
endmodule : tct_top

`default_nettype wire

/* File: tb/test_tick_clock_timer.sv */
// Self-checking bench for the tick clock timer top module.
// Assumes tct_pkg is compiled first and tct_cfg.svh is on the include path.
`default_nettype none
`include "tct_cfg.svh"

`define CHK(what, exp, got) begin n_compared++; \
  if ((got) !== (exp)) begin err_count++; \
  $display("MISMATCH %s expected %h seen %h", what, exp, got); end end

module test_tick_clock_timer;
  timeunit 1ns;
  timeprecision 1ns;
  import tct_pkg::*;
  localparam int HOLD = 40;
  localparam int DIV = 4;
  localparam int LIMIT = 20000;
  logic clock_i, nrst_i, ce_i, osc, wr, rd, irq;
  tct_addr_t addr;
  tct_nib_t wdata, rdata;
  int err_count, n_compared, cycles;

  tct_top #(.HOLD_CYCLES(HOLD), .PRESC_DIV(DIV)) dut_u (
    .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .low_speed_oscillator_i(osc), .mem_addr_i(addr), .mem_wr_i(wr),
    .mem_rd_i(rd), .mem_wdata_i(wdata), .mem_rdata_o(rdata), .irq_o(irq));

  // ----------------------------------------------------------------------
  // Bus and oscillator helpers
  // ----------------------------------------------------------------------
  // Waits n edges, then steps off the edge so outputs are settled.
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick

  task automatic wr_reg(input tct_addr_t a, input tct_nib_t d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask : wr_reg

  // Reads one word and compares it; data lands one cycle after the strobe.
  task automatic chk_reg(input tct_addr_t a, input tct_nib_t e,
                         input string nm);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
  endtask : chk_reg

  // Gives n counting steps of oscillator edges, then lets sampling settle.
  task automatic step(input int n);
    repeat (n * DIV) begin
      @(posedge clock_i);
      osc <= 1'b1;
      @(posedge clock_i);
      osc <= 1'b0;
    end
    tick(4);
  endtask : step

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    chk_reg(`TCT_ADDR_CTRL, 4'h0, "ctrl");
    chk_reg(`TCT_ADDR_LOW, 4'h0, "low");
    chk_reg(`TCT_ADDR_HIGH, 4'h0, "high");
    chk_reg(`TCT_ADDR_EN, 4'h0, "enable");
    chk_reg(`TCT_ADDR_FLAG, 4'h0, "flag");
    chk_reg(16'h1234, 4'h0, "unmapped");
    `CHK("irq", 1'b0, irq)
  endtask : t_reset

  task automatic t_ctrl;
    wr_reg(`TCT_ADDR_CTRL, 4'hd);
    chk_reg(`TCT_ADDR_CTRL, 4'h1, "ctrl");
    wr_reg(`TCT_ADDR_CTRL, 4'h0);
    chk_reg(`TCT_ADDR_CTRL, 4'h0, "ctrl");
    wr_reg(`TCT_ADDR_LOW, 4'h7);
    chk_reg(`TCT_ADDR_LOW, 4'h0, "low");
    wr_reg(`TCT_ADDR_EN, 4'hf);
    chk_reg(`TCT_ADDR_EN, 4'hf, "enable");
    wr_reg(`TCT_ADDR_EN, 4'h0);
  endtask : t_ctrl

  task automatic t_count;
    wr_reg(`TCT_ADDR_CTRL, 4'h3);
    step(5);
    chk_reg(`TCT_ADDR_LOW, 4'h5, "low");
    wr_reg(`TCT_ADDR_CTRL, 4'h0);
    step(3);
    chk_reg(`TCT_ADDR_LOW, 4'h5, "low");
    @(posedge clock_i);
    ce_i <= 1'b0;
    wr_reg(`TCT_ADDR_CTRL, 4'h2);
    ce_i <= 1'b1;
    chk_reg(`TCT_ADDR_LOW, 4'h5, "low");
    wr_reg(`TCT_ADDR_CTRL, 4'h1);
    step(1);
    chk_reg(`TCT_ADDR_LOW, 4'h6, "low");
    step(10);
    chk_reg(`TCT_ADDR_LOW, 4'h0, "low");
    chk_reg(`TCT_ADDR_HIGH, 4'h1, "high");
  endtask : t_count

  // A carry lands between the two reads; high stays held until it is read, or in the second run until the hold times out.
  task automatic t_hold;
    wr_reg(`TCT_ADDR_CTRL, 4'h3);
    step(15);
    chk_reg(`TCT_ADDR_LOW, 4'hf, "low");
    step(1);
    chk_reg(`TCT_ADDR_HIGH, 4'h0, "high held");
    chk_reg(`TCT_ADDR_HIGH, 4'h1, "high after");
    wr_reg(`TCT_ADDR_CTRL, 4'h3);
    step(15);
    chk_reg(`TCT_ADDR_LOW, 4'hf, "low");
    step(1);
    tick(HOLD + 10);
    chk_reg(`TCT_ADDR_HIGH, 4'h1, "high timeout");
  endtask : t_hold

  task automatic t_flags;
    wr_reg(`TCT_ADDR_CTRL, 4'h2);
    wr_reg(`TCT_ADDR_FLAG, 4'hf);
    wr_reg(`TCT_ADDR_CTRL, 4'h1);
    step(8);
    chk_reg(`TCT_ADDR_FLAG, 4'h1, "flag");
    tick(2);
    `CHK("irq masked", 1'b0, irq)
    wr_reg(`TCT_ADDR_EN, 4'h1);
    tick(2);
    `CHK("irq", 1'b1, irq)
    wr_reg(`TCT_ADDR_FLAG, 4'h0);
    chk_reg(`TCT_ADDR_FLAG, 4'h1, "flag");
    wr_reg(`TCT_ADDR_FLAG, 4'h1);
    chk_reg(`TCT_ADDR_FLAG, 4'h0, "flag");
    tick(2);
    `CHK("irq", 1'b0, irq)
    step(248);
    chk_reg(`TCT_ADDR_FLAG, 4'hf, "flag");
    wr_reg(`TCT_ADDR_EN, 4'h8);
    tick(2);
    `CHK("irq", 1'b1, irq)
    wr_reg(`TCT_ADDR_FLAG, 4'hf);
    wr_reg(`TCT_ADDR_EN, 4'h0);
  endtask : t_flags

  task automatic t_clear;
    wr_reg(`TCT_ADDR_CTRL, 4'h1);
    step(3);
    wr_reg(`TCT_ADDR_CTRL, 4'h3);
    step(2);
    chk_reg(`TCT_ADDR_LOW, 4'h2, "low");
    chk_reg(`TCT_ADDR_CTRL, 4'h1, "ctrl");
    wr_reg(`TCT_ADDR_CTRL, 4'h2);
    step(2);
    chk_reg(`TCT_ADDR_LOW, 4'h0, "low");
    chk_reg(`TCT_ADDR_HIGH, 4'h0, "high");
  endtask : t_clear

  // A reset in mid-run clears a running count, enables, flags and outputs.
  task automatic t_rerun;
    wr_reg(`TCT_ADDR_CTRL, 4'h1);
    wr_reg(`TCT_ADDR_EN, 4'hf);
    step(9);
    `CHK("irq", 1'b1, irq)
    chk_reg(`TCT_ADDR_LOW, 4'h9, "low");
    chk_reg(`TCT_ADDR_EN, 4'hf, "enable");
    @(posedge clock_i);
    nrst_i <= 1'b0;
    tick(3);
    `CHK("rdata reset", 4'h0, rdata)
    `CHK("irq reset", 1'b0, irq)
    @(posedge clock_i);
    nrst_i <= 1'b1;
    chk_reg(`TCT_ADDR_CTRL, 4'h0, "ctrl");
    chk_reg(`TCT_ADDR_LOW, 4'h0, "low");
    chk_reg(`TCT_ADDR_EN, 4'h0, "enable");
    chk_reg(`TCT_ADDR_FLAG, 4'h0, "flag");
  endtask : t_rerun

  // ----------------------------------------------------------------------
  // Clock, watchdog, verdict and main sequence
  // ----------------------------------------------------------------------
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Free-running 10 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // Cuts a hung run short and reports it as a mismatch.
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      $display("MISMATCH watchdog expected finish seen timeout");
      end_of_test();
    end
  end

  // Holds reset for 12 cycles, then runs every scenario in turn.
  initial begin
    nrst_i = 1'b0;
    ce_i = 1'b1;
    osc = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 4'h0;
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_reset();
    t_ctrl();
    t_count();
    t_hold();
    t_flags();
    t_clear();
    t_rerun();
    end_of_test();
  end
endmodule : test_tick_clock_timer

`default_nettype wire
